// *** verilog/vob_vertical_overflow.sv ***
// Vertical overflow register and vertical scan-line timing comparators
`timescale 1ns/10ps
module vob_vertical_overflow (
  input  wire logic             mclk,       // 20 MHz clock
  input  wire logic             arst_n,     // Async reset, active low
  input  wire vob_pkg::vob_wr_t wr_req,     // Indexed port write
  input  wire logic [7:0]       rd_index,   // Indexed port read index
  input  wire logic             protect_g0, // Group-zero write protection
  input  wire logic             line_tick,  // One pulse per scan line end
  input  wire logic             char_tick,  // One pulse per fetched unit
  output logic [7:0]            rd_data,    // Read data for rd_index
  output vob_pkg::vob_vert_t    vert_vals,  // Assembled 10-bit values
  output logic [9:0]            scan_line,  // Current scan line
  output logic                  vsync,      // Vertical sync active
  output logic                  vde,        // Vertical display enable
  output logic                  frame_wrap, // Pulse at frame end
  output logic [15:0]           mem_addr    // Display memory address
);
  import vob_pkg::*;

  // Register file behind the indexed data port
  logic [7:0]  ovf_reg, ovf_next;
  logic [7:0]  vt_low_reg, vt_low_next;
  logic [7:0]  vs_low_reg, vs_low_next;
  logic [7:0]  de_low_reg, de_low_next;
  logic [7:0]  msl_reg, msl_next;
  logic [7:0]  lc_low_reg, lc_low_next;
  logic [7:0]  sa_hi_reg, sa_hi_next;
  logic [7:0]  sa_lo_reg, sa_lo_next;
  logic [7:0]  rd_data_reg, rd_data_next;

  // Assembled values and vertical timing state
  vob_vert_t   vals;
  vob_vert_t   vals_reg, vals_next;
  logic [9:0]  line_reg, line_next;
  logic        vsync_reg, vsync_next;
  logic        vde_reg, vde_next;
  logic        wrap_reg, wrap_next;
  logic [15:0] addr_reg, addr_next;
  vob_phase_t  phase_reg, phase_next;

  // Register writes through the indexed data port
  always_comb begin
    ovf_next    = ovf_reg;
    vt_low_next = vt_low_reg;
    vs_low_next = vs_low_reg;
    de_low_next = de_low_reg;
    msl_next    = msl_reg;
    lc_low_next = lc_low_reg;
    sa_hi_next  = sa_hi_reg;
    sa_lo_next  = sa_lo_reg;
    if (wr_req.wr) begin
      case (wr_req.index)
        VOB_IDX_OVERFLOW: begin
          if (protect_g0) begin
            // Only line compare bit 8 stays writable
            ovf_next = (ovf_reg & VOB_OVF_PROT_MASK) |
                       (wr_req.data & ~VOB_OVF_PROT_MASK);
          end else begin
            ovf_next = wr_req.data;
          end
        end
        VOB_IDX_VTOTAL_LOW:   vt_low_next = wr_req.data;
        VOB_IDX_VSYNC_LOW:    vs_low_next = wr_req.data;
        VOB_IDX_DE_END_LOW:   de_low_next = wr_req.data;
        VOB_IDX_MAX_SCAN:     msl_next    = wr_req.data;
        VOB_IDX_LINE_CMP_LOW: lc_low_next = wr_req.data;
        VOB_IDX_START_HIGH:   sa_hi_next  = wr_req.data;
        VOB_IDX_START_LOW:    sa_lo_next  = wr_req.data;
        default: ;
      endcase
    end
  end

  // Read mux for the indexed data port
  always_comb begin
    case (rd_index)
      VOB_IDX_OVERFLOW:     rd_data_next = ovf_reg;
      VOB_IDX_VTOTAL_LOW:   rd_data_next = vt_low_reg;
      VOB_IDX_VSYNC_LOW:    rd_data_next = vs_low_reg;
      VOB_IDX_DE_END_LOW:   rd_data_next = de_low_reg;
      VOB_IDX_MAX_SCAN:     rd_data_next = msl_reg;
      VOB_IDX_LINE_CMP_LOW: rd_data_next = lc_low_reg;
      VOB_IDX_START_HIGH:   rd_data_next = sa_hi_reg;
      VOB_IDX_START_LOW:    rd_data_next = sa_lo_reg;
      default:              rd_data_next = VOB_RESET_BYTE;
    endcase
  end

  // Assembly of the 10-bit values from overflow, max scan and low bytes
  // Comparators read these unregistered values, so a write acts at once
  always_comb begin
    vals.vsync_start = {ovf_reg[VOB_OVF_VS_B9], ovf_reg[VOB_OVF_VS_B8],
                        vs_low_reg};
    vals.de_end      = {ovf_reg[VOB_OVF_DE_B9], ovf_reg[VOB_OVF_DE_B8],
                        de_low_reg};
    vals.vtotal      = {ovf_reg[VOB_OVF_VT_B9], ovf_reg[VOB_OVF_VT_B8],
                        vt_low_reg};
    vals.line_cmp    = {msl_reg[VOB_MSL_LC_B9], ovf_reg[VOB_OVF_LC_B8],
                        lc_low_reg};
    vals_next        = vals;
  end

  // Scan-line counter, vertical comparators and address counter
  always_comb begin
    line_next     = line_reg;
    vsync_next    = vsync_reg;
    vde_next      = vde_reg;
    wrap_next     = 1'b0;
    addr_next     = addr_reg;
    phase_next    = phase_reg;
    // Fetches advance the address only inside active lines
    if (char_tick && vde_reg) begin
      addr_next = addr_reg + VOB_ADDR_ONE;
    end
    if (line_tick) begin
      if (line_reg == vals.vtotal + VOB_LINE_ONE) begin
        // Frame wraps after total plus two lines
        line_next     = VOB_LINE_ZERO;
        wrap_next     = 1'b1;
        vde_next      = 1'b1;
        phase_next    = VOB_ST_ACTIVE;
        // Upper screen fetch begins at the start address
        addr_next     = {sa_hi_reg, sa_lo_reg};
      end else begin
        line_next = line_reg + VOB_LINE_ONE;
        // A fetch on the same cycle is kept unless the split restarts
        if (line_reg + VOB_LINE_ONE == vals.line_cmp) begin
          // Split screen restarts fetch at zero
          addr_next = VOB_ADDR_ZERO;
        end
      end
      // Sync starts at sync start line, ends at frame wrap
      if (line_reg + VOB_LINE_ONE == vals.vsync_start) begin
        vsync_next = 1'b1;
      end else if (line_reg == vals.vtotal + VOB_LINE_ONE) begin
        vsync_next = 1'b0;
      end
      // Display enable ends after the last active line
      case (phase_reg)
        VOB_ST_ACTIVE: begin
          if (line_reg == vals.de_end) begin
            vde_next   = 1'b0;
            phase_next = VOB_ST_BLANK;
          end
        end
        VOB_ST_BLANK: ;
        default: phase_next = VOB_ST_ACTIVE;
      endcase
      // Frame wrap reopens the active phase
      if (line_reg == vals.vtotal + VOB_LINE_ONE) begin
        vde_next   = 1'b1;
        phase_next = VOB_ST_ACTIVE;
      end
    end
  end

  // State registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      // Register file
      ovf_reg      <= VOB_RESET_BYTE;
      vt_low_reg   <= VOB_RESET_BYTE;
      vs_low_reg   <= VOB_RESET_BYTE;
      de_low_reg   <= VOB_RESET_BYTE;
      msl_reg      <= VOB_RESET_BYTE;
      lc_low_reg   <= VOB_RESET_BYTE;
      sa_hi_reg    <= VOB_RESET_BYTE;
      sa_lo_reg    <= VOB_RESET_BYTE;
      rd_data_reg  <= VOB_RESET_BYTE;
      // Timing state
      vals_reg     <= '0;
      line_reg     <= VOB_LINE_ZERO;
      vsync_reg    <= 1'b0;
      vde_reg      <= 1'b1;
      wrap_reg     <= 1'b0;
      addr_reg     <= VOB_ADDR_ZERO;
      phase_reg    <= VOB_ST_ACTIVE;
    end else begin
      // Register file
      ovf_reg      <= ovf_next;
      vt_low_reg   <= vt_low_next;
      vs_low_reg   <= vs_low_next;
      de_low_reg   <= de_low_next;
      msl_reg      <= msl_next;
      lc_low_reg   <= lc_low_next;
      sa_hi_reg    <= sa_hi_next;
      sa_lo_reg    <= sa_lo_next;
      rd_data_reg  <= rd_data_next;
      // Timing state
      vals_reg     <= vals_next;
      line_reg     <= line_next;
      vsync_reg    <= vsync_next;
      vde_reg      <= vde_next;
      wrap_reg     <= wrap_next;
      addr_reg     <= addr_next;
      phase_reg    <= phase_next;
    end
  end

  // Outputs straight from flip-flops
  assign rd_data    = rd_data_reg;
  assign vert_vals  = vals_reg;
  assign scan_line  = line_reg;
  assign vsync      = vsync_reg;
  assign vde        = vde_reg;
  assign frame_wrap = wrap_reg;
  assign mem_addr   = addr_reg;
endmodule

// *** verilog/vob_pkg.sv ***
// Package for the vertical overflow bits block: offsets, fields, types
package vob_pkg;
  localparam logic [7:0] VOB_IDX_VTOTAL_LOW   = 8'h06;
  localparam logic [7:0] VOB_IDX_OVERFLOW     = 8'h07;
  localparam logic [7:0] VOB_IDX_MAX_SCAN     = 8'h09;
  localparam logic [7:0] VOB_IDX_START_HIGH   = 8'h0c;
  localparam logic [7:0] VOB_IDX_START_LOW    = 8'h0d;
  localparam logic [7:0] VOB_IDX_VSYNC_LOW    = 8'h10;
  localparam logic [7:0] VOB_IDX_DE_END_LOW   = 8'h12;
  localparam logic [7:0] VOB_IDX_LINE_CMP_LOW = 8'h18;
  // Field positions inside the overflow register and the max scan register
  localparam int VOB_OVF_VS_B9  = 7;
  localparam int VOB_OVF_DE_B9  = 6;
  localparam int VOB_OVF_VT_B9  = 5;
  localparam int VOB_OVF_LC_B8  = 4;
  localparam int VOB_OVF_VS_B8  = 2;
  localparam int VOB_OVF_DE_B8  = 1;
  localparam int VOB_OVF_VT_B8  = 0;
  localparam int VOB_MSL_LC_B9  = 6;
  // Overflow bits guarded by the group-zero protection
  localparam logic [7:0] VOB_OVF_PROT_MASK = 8'hef;
  localparam logic [7:0] VOB_RESET_BYTE    = 8'h00;
  localparam logic [9:0] VOB_LINE_ZERO     = 10'h000;
  localparam logic [15:0] VOB_ADDR_ZERO    = 16'h0000;
  localparam logic [15:0] VOB_ADDR_ONE     = 16'h0001;
  localparam logic [9:0] VOB_LINE_ONE      = 10'h001;

  // Register write request from the indexed port
  typedef struct packed {
    logic       wr;
    logic [7:0] index;
    logic [7:0] data;
  } vob_wr_t;

  // Assembled 10-bit vertical values
  typedef struct packed {
    logic [9:0] vtotal;
    logic [9:0] vsync_start;
    logic [9:0] de_end;
    logic [9:0] line_cmp;
  } vob_vert_t;

  typedef enum logic [1:0] {
    VOB_ST_ACTIVE,
    VOB_ST_BLANK
  } vob_phase_t;
endpackage

// *** sim/vob_vertical_overflow_assertions.sv ***
// Port checker for the vertical overflow block
`timescale 1ns/10ps
module vob_vertical_overflow_assertions (
  input wire logic               mclk,       // Clock
  input wire logic               arst_n,     // Reset, active low
  input wire vob_pkg::vob_wr_t   wr_req,     // Register write
  input wire logic               protect_g0, // Write protection
  input wire logic               line_tick,  // Line end pulse
  input wire logic               char_tick,  // Fetch pulse
  input wire vob_pkg::vob_vert_t vert_vals,  // Assembled values
  input wire logic [9:0]         scan_line,  // Current line
  input wire logic               vsync,      // Vertical sync
  input wire logic               vde,        // Display enable
  input wire logic               frame_wrap, // Frame end pulse
  input wire logic [15:0]        mem_addr    // Memory address
);
  import vob_pkg::*;
  logic       ow;
  logic [9:0] wrap_ln;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Overflow write strobe and the line on which the frame wraps
  assign ow = wr_req.wr && wr_req.index == VOB_IDX_OVERFLOW;
  assign wrap_ln = vert_vals.vtotal + VOB_LINE_ONE;
  // High bits follow a lone overflow write two edges later
  property hi_p(logic pr, int hi, int lo, logic [9:0] v);
    logic [7:0] d;
    (ow && pr, d = wr_req.data) ##1 !ow |=> v[9:8] == {d[hi], d[lo]};
  endproperty
  vs_bits_a: assert property (hi_p(!protect_g0, 7, 2,
    vert_vals.vsync_start)) else $error("sync start high bits wrong");
  de_bits_a: assert property (hi_p(!protect_g0, 6, 1,
    vert_vals.de_end)) else $error("display end high bits wrong");
  vt_bits_a: assert property (hi_p(!protect_g0, 5, 0,
    vert_vals.vtotal)) else $error("vertical total high bits wrong");
  lc_bit_a: assert property (ow ##1 !ow |=>
    vert_vals.line_cmp[8] == $past(wr_req.data[4], 2))
    else $error("line compare bit 8 wrong");
  prot_keep_a: assert property (ow && protect_g0 ##1 !ow |=>
    $stable(vert_vals.vtotal[9:8])) else $error("protected bits changed");
  frame_wrap_a: assert property (line_tick && scan_line == wrap_ln
    |=> scan_line == VOB_LINE_ZERO && frame_wrap && vde && !vsync)
    else $error("frame wrap wrong");
  split_rst_a: assert property (line_tick && !char_tick &&
    scan_line + VOB_LINE_ONE == vert_vals.line_cmp && scan_line != wrap_ln
    |=> mem_addr == VOB_ADDR_ZERO) else $error("split restart missed");
  de_end_a: assert property (line_tick &&
    scan_line == vert_vals.de_end && scan_line != wrap_ln |=> !vde)
    else $error("display enable did not end");
  cover property (frame_wrap);
  cover property (ow && protect_g0);
  cover property (line_tick && scan_line + VOB_LINE_ONE == vert_vals.line_cmp);
endmodule

bind vob_vertical_overflow vob_vertical_overflow_assertions i_chk (
  .mclk(mclk), .arst_n(arst_n), .wr_req(wr_req), .protect_g0(protect_g0),
  .line_tick(line_tick), .char_tick(char_tick), .vert_vals(vert_vals),
  .scan_line(scan_line), .vsync(vsync), .vde(vde), .frame_wrap(frame_wrap),
  .mem_addr(mem_addr));

// *** sim/vob_scan_src.sv ***
// Scan timing source model: line and fetch ticks
`timescale 1ns/10ps
module vob_scan_src (
  input  wire logic mclk,      // Clock
  input  wire logic run,       // Ticks only while high
  output logic      line_tick, // Line end pulse
  output logic      char_tick  // Fetch pulse
);
  logic [2:0] cnt_reg;
  // Eight clocks a line, three fetches clear of the line end
  always_ff @(posedge mclk) begin
    cnt_reg <= run ? cnt_reg + 3'h1 : 3'h0;
  end
  assign line_tick = run && cnt_reg == 3'h7;
  assign char_tick = run && cnt_reg inside {3'h1, 3'h2, 3'h3};
endmodule

// *** sim/vob_vertical_overflow_test.sv ***
// Testbench for the vertical overflow block
`timescale 1ns/10ps
module vob_vertical_overflow_test;
  import vob_pkg::*;
  localparam logic [7:0] UNMAP = 8'h3f;
  logic        mclk, arst_n, protect_g0, run, rd_go, rd_v;
  logic        line_tick, char_tick, vsync, vde, frame_wrap;
  logic [7:0]  rd_index, rd_data;
  logic [7:0]  m [256];
  logic [9:0]  scan_line;
  logic [15:0] mem_addr;
  logic [39:0] rq [$];
  vob_wr_t     wr_req;
  vob_vert_t   vert_vals;
  int          num_errors, check_count;
  vob_vertical_overflow i_dut (.mclk(mclk), .arst_n(arst_n), .wr_req(wr_req),
    .rd_index(rd_index), .protect_g0(protect_g0), .line_tick(line_tick),
    .char_tick(char_tick), .rd_data(rd_data), .vert_vals(vert_vals),
    .scan_line(scan_line), .vsync(vsync), .vde(vde),
    .frame_wrap(frame_wrap), .mem_addr(mem_addr));
  vob_scan_src i_src (.mclk(mclk), .run(run), .line_tick(line_tick),
    .char_tick(char_tick));
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  // Register write, mirrored into the expected register image
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge mclk);
    wr_req <= '{1'b1, i, d};
    if (i == VOB_IDX_OVERFLOW && protect_g0)
      m[i] = (m[i] & VOB_OVF_PROT_MASK) | (d & ~VOB_OVF_PROT_MASK);
    else if (i != UNMAP)
      m[i] = d;
    @(posedge mclk);
    wr_req.wr <= 1'b0;
  endtask
  // Read request; the monitor below compares the answer
  task automatic rd(input logic [7:0] i);
    @(posedge mclk);
    rd_index <= i;
    rd_go <= 1'b1;
    rq.push_back(40'(m[i]));
    @(posedge mclk);
    rd_go <= 1'b0;
  endtask
  always @(posedge mclk) begin
    rd_v <= rd_go;
    if (rd_v === 1'b1) chk(40'(rd_data), rq.pop_front());
  end
  function automatic logic [39:0] vv();
    logic [7:0] o;
    o = m[VOB_IDX_OVERFLOW];
    return {o[5], o[0], m[VOB_IDX_VTOTAL_LOW],
      o[7], o[2], m[VOB_IDX_VSYNC_LOW],
      o[6], o[1], m[VOB_IDX_DE_END_LOW],
      m[VOB_IDX_MAX_SCAN][6], o[4], m[VOB_IDX_LINE_CMP_LOW]};
  endfunction
  // Random fill, read back, protected pass, unmapped place
  task automatic reg_test();
    logic [7:0] ix [8] = '{VOB_IDX_VTOTAL_LOW, VOB_IDX_OVERFLOW,
      VOB_IDX_MAX_SCAN, VOB_IDX_START_HIGH, VOB_IDX_START_LOW,
      VOB_IDX_VSYNC_LOW, VOB_IDX_DE_END_LOW, VOB_IDX_LINE_CMP_LOW};
    rd(VOB_IDX_OVERFLOW);
    for (int p = 0; p < 2; p++) begin
      protect_g0 <= p[0];
      foreach (ix[k]) wr(ix[k], 8'($urandom));
      foreach (ix[k]) rd(ix[k]);
      repeat (3) @(posedge mclk);
      chk(vert_vals, vv());
    end
    wr(UNMAP, 8'h5a);
    rd(UNMAP);
    $display("register test done");
  endtask
  // Seven-line frames: sync from line 5, five active, split at line 2,
  // then a frame with line compare past the active lines, no split
  task automatic frame_test();
    logic [15:0] s, ea;
    logic [39:0] ev;
    int          k;
    protect_g0 <= 1'b0;
    wr(VOB_IDX_OVERFLOW, 8'h00);
    wr(VOB_IDX_MAX_SCAN, 8'h00);
    wr(VOB_IDX_VTOTAL_LOW, 8'h05);
    wr(VOB_IDX_VSYNC_LOW, 8'h05);
    wr(VOB_IDX_DE_END_LOW, 8'h04);
    wr(VOB_IDX_LINE_CMP_LOW, 8'h02);
    s = {m[VOB_IDX_START_HIGH], m[VOB_IDX_START_LOW]};
    run <= 1'b1;
    for (int f = 0; f < 2; f++) begin
      if (f == 1) wr(VOB_IDX_LINE_CMP_LOW, 8'h3c);
      for (int n = 0; n < 200 && frame_wrap !== 1'b1; n++) @(posedge mclk);
      for (int l = 0; l < 7; l++) begin
        for (int n = 0; n < 20 && scan_line !== 10'(l); n++) @(posedge mclk);
        k = l > 5 ? 5 : l;
        ea = (l < 2 || f == 1) ? s + 16'(3 * k) : 16'(3 * (k - 2));
        ev = {12'h0, 10'(l), l >= 5, l <= 4, ea};
        chk({12'h0, scan_line, vsync, vde, mem_addr}, ev);
      end
    end
    $display("frame test done");
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    {arst_n, protect_g0, run, rd_go, rd_index} = '0;
    wr_req = '0;
    foreach (m[i]) m[i] = 8'h00;
    void'($urandom(32'h5633));
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    reg_test();
    frame_test();
    repeat (4) @(posedge mclk);
    finish_test();
  end
  // Watchdog well past the expected run of a few hundred cycles
  initial begin
    #200000;
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end
endmodule
